//--- design/kds_defines.vh
`ifndef KBS_DEFINES_VH
`define KBS_DEFINES_VH
// Grid count per frame (16 digits at most)
`define KBS_NUM_GRIDS 16
// Cycles per grid slot at 125 MHz (8 us nominal slot)
`define KBS_SLOT_NS 8000
`define KBS_CLK_NS 8
`define KBS_SLOT_CYC (`KBS_SLOT_NS / `KBS_CLK_NS)
// Key matrix shape
`define KBS_KEY_COLS 12
`define KBS_KEY_ROWS 2
`endif

//--- design/kds_slot_timer.v
`timescale 1ns/1ps
`include "kds_defines.vh"
module kbs_slot_timer #(
  parameter SLOT_CYC = `KBS_SLOT_CYC
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Slot end pulse
  output reg slot_end
);
  reg [15:0] cnt_reg;

  always @(posedge clk)
  begin
    if (reset)
    begin
      cnt_reg <= 16'h0000;
      slot_end <= 1'b0;
    end
    else if (cnt_reg == SLOT_CYC[15:0] - 16'h0001)
    begin
      cnt_reg <= 16'h0000;
      slot_end <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
      slot_end <= 1'b0;
    end
  end
endmodule

//--- design/kds_scheduler.v
// How it works
// - One key-scan cycle equals one frame
// - Store 12 by 2 key matrix into RAM
// - Display on: scan only at frame end
// - Display off: scan cycles back to back
// - Grids inactive throughout the scan slot
`timescale 1ns/1ps
`include "kds_defines.vh"
module kbs_scheduler #(
  parameter NUM_GRIDS = `KBS_NUM_GRIDS,
  parameter SLOT_CYC = `KBS_SLOT_CYC,
  parameter KEY_COLS = `KBS_KEY_COLS,
  parameter KEY_ROWS = `KBS_KEY_ROWS
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Control
  input wire display_on,
  // Key matrix
  input wire [KEY_ROWS-1:0] key_rows,
  output reg [KEY_COLS-1:0] key_col_drive,
  // Display grids
  output reg [NUM_GRIDS-1:0] grid_out,
  // Status
  output reg scan_active,
  output reg frame_done,
  // Key RAM read port
  input wire [3:0] key_rd_col,
  output reg [KEY_ROWS-1:0] key_rd_data
);
  // Hold: display switched off mid-grid, dark until the next slot boundary
  localparam [1:0] ST_GRID = 2'b00;
  localparam [1:0] ST_SCAN = 2'b01;
  localparam [1:0] ST_HOLD = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [4:0] grid_idx_reg;
  reg [4:0] grid_idx_next;
  reg [3:0] col_idx_reg;
  reg [3:0] col_idx_next;
  reg frame_done_next;
  reg ram_we;
  reg [KEY_ROWS-1:0] key_ram [0:KEY_COLS-1];
  wire slot_end;
  integer i;

  kbs_slot_timer #(
    .SLOT_CYC(SLOT_CYC)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .slot_end(slot_end)
  );

  function [NUM_GRIDS-1:0] onehot;
    input [4:0] idx;
    begin
      onehot = {{(NUM_GRIDS-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  function [KEY_COLS-1:0] col_sel;
    input [3:0] idx;
    begin
      col_sel = {{(KEY_COLS-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  function last_grid;
    input [4:0] idx;
    begin
      last_grid = (idx == NUM_GRIDS[4:0] - 5'h01);
    end
  endfunction

  function last_col;
    input [3:0] idx;
    begin
      last_col = (idx == KEY_COLS[3:0] - 4'h1);
    end
  endfunction

  // Columns are scanned one per slot tick; a scan slot spans KEY_COLS ticks
  always @*
  begin
    state_next = state_reg;
    grid_idx_next = grid_idx_reg;
    col_idx_next = col_idx_reg;
    frame_done_next = 1'b0;
    ram_we = 1'b0;
    case (state_reg)
      ST_GRID:
      begin
        if (!display_on)
        begin
          // Scan starts on a slot boundary so column 0 gets a full slot
          grid_idx_next = 5'h00;
          col_idx_next = 4'h0;
          if (slot_end)
            state_next = ST_SCAN;
          else
            state_next = ST_HOLD;
        end
        else if (slot_end)
        begin
          if (last_grid(grid_idx_reg))
          begin
            grid_idx_next = 5'h00;
            col_idx_next = 4'h0;
            state_next = ST_SCAN;
          end
          else
            grid_idx_next = grid_idx_reg + 5'h01;
        end
      end
      ST_HOLD:
      begin
        if (slot_end)
        begin
          col_idx_next = 4'h0;
          state_next = ST_SCAN;
        end
      end
      ST_SCAN:
      begin
        if (slot_end)
        begin
          // Rows sampled at slot end so the column drive has settled
          ram_we = 1'b1;
          if (last_col(col_idx_reg))
          begin
            col_idx_next = 4'h0;
            frame_done_next = 1'b1;
            if (display_on)
              state_next = ST_GRID;
            else
              state_next = ST_SCAN;
          end
          else
            col_idx_next = col_idx_reg + 4'h1;
        end
      end
      default:
      begin
        state_next = ST_SCAN;
        col_idx_next = 4'h0;
        grid_idx_next = 5'h00;
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= ST_SCAN;
      grid_idx_reg <= 5'h00;
      col_idx_reg <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
      grid_idx_reg <= grid_idx_next;
      col_idx_reg <= col_idx_next;
    end
  end

  // Outputs follow the next state, so every grid gets the same slot length
  always @(posedge clk)
  begin
    if (reset)
    begin
      grid_out <= {NUM_GRIDS{1'b0}};
      key_col_drive <= {KEY_COLS{1'b0}};
      scan_active <= 1'b0;
      frame_done <= 1'b0;
    end
    else
    begin
      frame_done <= frame_done_next;
      if (state_next == ST_GRID)
        grid_out <= onehot(grid_idx_next);
      else
        grid_out <= {NUM_GRIDS{1'b0}};
      if (state_next == ST_SCAN)
      begin
        scan_active <= 1'b1;
        key_col_drive <= col_sel(col_idx_next);
      end
      else
      begin
        scan_active <= 1'b0;
        key_col_drive <= {KEY_COLS{1'b0}};
      end
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      for (i = 0; i < KEY_COLS; i = i + 1)
        key_ram[i] <= {KEY_ROWS{1'b0}};
    end
    else if (ram_we)
      key_ram[col_idx_reg] <= key_rows;
  end

  always @(posedge clk)
  begin
    if (reset)
      key_rd_data <= {KEY_ROWS{1'b0}};
    else if (key_rd_col < KEY_COLS[3:0])
      key_rd_data <= key_ram[key_rd_col];
    else
      key_rd_data <= {KEY_ROWS{1'b0}};
  end
endmodule

//--- dv/kbs_key_matrix.sv
`timescale 1ns/1ps
module kbs_key_matrix (
  // Keys
  input wire [11:0] key_col_drive,
  input wire [23:0] pressed,
  // Rows, pulled down when no column drives
  output logic [1:0] key_rows
);
  always_comb
  begin
    key_rows = 2'h0;
    for (int c = 0; c < 12; c++)
      if (key_col_drive[c])
        key_rows |= pressed[2*c+:2];
  end
endmodule

//--- dv/kbs_monitor.sv
`timescale 1ns/1ps
module kbs_monitor (
  // Clock
  input wire clk,
  input wire reset,
  // Watched
  input wire display_on,
  input wire [11:0] key_col_drive,
  input wire [15:0] grid_out,
  input wire scan_active,
  input wire frame_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_grid_blank: assert property (scan_active |-> !grid_out)
    else $error("grid lit");
  chk_col_single: assert property (scan_active |-> $onehot(key_col_drive))
    else $error("cols");
  chk_grid_single: assert property ($onehot0(grid_out))
    else $error("grids");
  chk_off_repeat: assert property (frame_done && !display_on |=> scan_active)
    else $error("gap");
  chk_on_grid: assert property (frame_done && display_on |=> grid_out == 16'h1)
    else $error("no grid");
  chk_frame_gap: assert property (frame_done |=> !frame_done [*8])
    else $error("short");
  cover property (frame_done && display_on);
  cover property (frame_done && !display_on);
  cover property ($fell(scan_active));
endmodule
bind kbs_scheduler kbs_monitor i_kbs_monitor (.clk, .reset, .display_on, .key_col_drive,
  .grid_out, .scan_active, .frame_done);

//--- dv/keyscan_display_scheduler_bench.sv
`timescale 1ns/1ps
module keyscan_display_scheduler_bench;
  logic clk = 1'h0, reset = 1'h1, display_on = 1'h0;
  logic [3:0] key_rd_col = 4'h0;
  logic [23:0] pressed = 24'h0;
  wire [1:0] key_rows, key_rd_data;
  wire [11:0] key_col_drive;
  wire [15:0] grid_out;
  wire scan_active, frame_done;
  int n_errors = 0, checks = 0, n;
  always #4 clk = ~clk;
  kbs_scheduler #(.SLOT_CYC(4)) i_kbs_scheduler (.clk, .reset, .display_on, .key_rows,
    .key_col_drive, .grid_out, .scan_active, .frame_done, .key_rd_col, .key_rd_data);
  kbs_key_matrix i_kbs_key_matrix (.key_col_drive, .pressed, .key_rows);
  task automatic check(input logic [31:0] seen, exp);
    checks++;
    n_errors += (seen !== exp);
    if (seen !== exp)
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Counts cycles to the next scan end; first call may end a partial scan
  task automatic wait_done;
    n = 0;
    do @(negedge clk); while (++n < 300 && frame_done !== 1'h1);
  endtask
  task automatic scan_mode(input logic on, input logic [23:0] keys, input int gap);
    @(posedge clk);
    display_on <= on;
    pressed <= keys;
    wait_done;
    wait_done;
    check(n, gap);
    check(scan_active, !on);
    check(grid_out, on ? 16'h0001 : 16'h0000);
    for (int c = 0; c < 13; c++)
    begin
      @(posedge clk) key_rd_col <= c[3:0];
      repeat (2) @(negedge clk);
      check(key_rd_data, c < 12 ? keys[2*c+:2] : 0);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    scan_mode(1'h0, 24'ha5c396, 48);
    scan_mode(1'h1, 24'h3c0f81, 112);
    scan_mode(1'h0, 24'h5a0ff0, 48);
    tally_and_finish;
  end
  initial
  begin
    #20000;
    n_errors++;
    tally_and_finish;
  end
endmodule
